/* design/splice_fields.sv */
// Composer of the splice-request fields of a cue message, sent byte by byte
// Notes on behaviour
// (RULE1) Cue source accepts only 0, 4, 8, 12
// (RULE2) Sources: embedded, automation, live, local replacement
// (RULE3) Event number generated internally, low 28 bits
// (RULE4) Event id joins source and generated number
// (RULE5) Program id is a two-byte unsigned field
// (RULE6) Pre-roll ms, used only for normal types
// (RULE7) Break tenths, used only for start types
// (RULE8) Avail number 8 bits, zero means unused
// (RULE9) Avails expected 8 bits, zero voids avail
// (RULE10) Auto-return needs flag, duration, start type
// (RULE11) Auto-return flag fixed at 0x00
// (RULE12) Insert type 8 bits, five operations
// (RULE13) Event id: source in top four bits
module splice_fields
    import splice_pkg::*;
(
    input  wire logic                  mclk,           // System clock, 100 MHz
    input  wire logic                  rst_n,          // Synchronous reset, active low
    input  wire logic                  reqValid,       // Configuration offers a request
    output logic                       reqReady,       // Composer idle, request can be taken
    input  wire logic [7:0]            insertType,     // Splice insert type
    input  wire logic [SRC_W-1:0]      cueSource,      // Cue-source code
    input  wire logic [15:0]           programId,      // Unique program identifier
    input  wire logic [15:0]           preRollMs,      // Pre-roll in milliseconds
    input  wire logic [15:0]           breakTenths,    // Break duration in tenths of a second
    input  wire logic [7:0]            availNum,       // Avail number
    input  wire logic [7:0]            availsExpected, // Expected avail count
    output logic                       reqError,       // Pulse: request refused
    output logic                       outValid,       // Byte stream valid
    input  wire logic                  outReady,       // Inserter takes the byte
    output logic [BYTE_W-1:0]          outData,        // Field byte, most significant first
    output logic                       outFirst,       // First byte of a block
    output logic                       outLast,        // Last byte of a block
    output logic [EVID_W-1:0]          eventId,        // Event id of the block in flight
    output cue_src_t                   eventSource,    // Decoded source of that block
    output logic                       autoReturnBit   // Auto-return bit for the section
);

    typedef enum logic {ST_IDLE, ST_SEND} state_t;

    event_num_if evIf ();  // Link to the number generator

    event_counter uCounter
    (
        .mclk  (mclk),
        .rst_n (rst_n),
        .evIf  (evIf)
    );

    state_t              state_reg,    state_next;     // Sequencer state
    logic [MSG_W-1:0]    msg_reg,      msg_next;       // Bytes still to send
    logic [IDX_W-1:0]    idx_reg,      idx_next;       // Index of the byte on outData
    logic                ready_reg,    ready_next;     // Request ready
    logic                err_reg,      err_next;       // Refusal pulse
    logic                valid_reg,    valid_next;     // Stream valid
    logic [BYTE_W-1:0]   data_reg,     data_next;      // Stream byte
    logic                first_reg,    first_next;     // First flag
    logic                last_reg,     last_next;      // Last flag
    logic [EVID_W-1:0]   evid_reg,     evid_next;      // Event id
    cue_src_t            src_reg,      src_next;       // Source of block
    logic                autoRet_reg,  autoRet_next;   // Auto-return bit
    logic [7:0]          type_reg,     type_next;      // Insert type of block

    logic                srcOk;       // Source code legal
    logic                typeOk;      // Insert type legal
    logic                isStart;     // Either start type
    logic                usesPreRoll; // Normal start or normal end
    logic [15:0]         preField;    // Pre-roll as sent
    logic [15:0]         brkField;    // Break as sent
    logic [EVID_W-1:0]   newEvid;     // Id for a new block

    // Request decode: only the legal codes pass
    always_comb
    begin
        srcOk       = (cueSource[1:0] == 2'b00);                          // [RULE1]
        typeOk      = (insertType >= TYPE_START_NORMAL) && (insertType <= TYPE_CANCEL);  // [RULE12]
        isStart     = (insertType == TYPE_START_NORMAL) || (insertType == TYPE_START_IMMED);
        usesPreRoll = (insertType == TYPE_START_NORMAL) || (insertType == TYPE_END_NORMAL);
        // Ignored fields are sent as zero so the splicer never sees stale values
        preField    = usesPreRoll ? preRollMs : 16'h0000;                 // [RULE6]
        brkField    = isStart ? breakTenths : 16'h0000;                   // [RULE7]
        newEvid     = {cueSource, evIf.number};                           // [RULE4] [RULE13]
    end

    // Sequencer next state
    always_comb
    begin
        state_next   = state_reg;
        msg_next     = msg_reg;
        idx_next     = idx_reg;
        err_next     = 1'b0;
        valid_next   = valid_reg;
        data_next    = data_reg;
        first_next   = first_reg;
        last_next    = last_reg;
        evid_next    = evid_reg;
        src_next     = src_reg;
        autoRet_next = autoRet_reg;
        type_next    = type_reg;
        evIf.advance = 1'b0;
        unique case (state_reg)
            ST_IDLE:
            begin
                if (reqValid)
                begin
                    if (srcOk && typeOk)
                    begin
                        // Block layout: type, id, program, pre-roll, break, avails, flag
                        msg_next     = {insertType, newEvid, programId,   // [RULE5]
                                        preField, brkField,
                                        availNum, availsExpected,         // [RULE8] [RULE9]
                                        AUTO_RETURN_FLAG} << BYTE_W;      // [RULE11]
                        data_next    = insertType;
                        idx_next     = IDX_TYPE;
                        valid_next   = 1'b1;
                        first_next   = 1'b1;
                        last_next    = 1'b0;
                        evid_next    = newEvid;
                        src_next     = cue_src_t'(cueSource);             // [RULE2]
                        type_next    = insertType;
                        // Flag is fixed at zero, so this stays low in practice
                        autoRet_next = isStart && (AUTO_RETURN_FLAG != 8'h00)
                                       && (breakTenths != 16'h0000);      // [RULE10]
                        evIf.advance = 1'b1;                              // [RULE3]
                        state_next   = ST_SEND;
                    end
                    else
                    begin
                        err_next = 1'b1;                                  // [RULE1]
                    end
                end
            end
            ST_SEND:
            begin
                if (outReady)
                begin
                    if (idx_reg == IDX_LAST)
                    begin
                        valid_next = 1'b0;
                        last_next  = 1'b0;
                        first_next = 1'b0;
                        state_next = ST_IDLE;
                    end
                    else
                    begin
                        data_next  = msg_reg[MSG_W-1 -: BYTE_W];
                        msg_next   = msg_reg << BYTE_W;
                        idx_next   = idx_reg + 4'h1;
                        first_next = 1'b0;
                        last_next  = (idx_reg + 4'h1) == IDX_LAST;
                    end
                end
            end
        endcase
        ready_next = (state_next == ST_IDLE);
    end

    // Sequencer registers
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            state_reg   <= ST_IDLE;
            msg_reg     <= '0;
            idx_reg     <= IDX_TYPE;
            ready_reg   <= 1'b1;
            err_reg     <= 1'b0;
            valid_reg   <= 1'b0;
            data_reg    <= 8'h00;
            first_reg   <= 1'b0;
            last_reg    <= 1'b0;
            evid_reg    <= EVID_RESET;
            src_reg     <= SRC_EMBEDDED;
            autoRet_reg <= 1'b0;
            type_reg    <= 8'h00;
        end
        else
        begin
            state_reg   <= state_next;
            msg_reg     <= msg_next;
            idx_reg     <= idx_next;
            ready_reg   <= ready_next;
            err_reg     <= err_next;
            valid_reg   <= valid_next;
            data_reg    <= data_next;
            first_reg   <= first_next;
            last_reg    <= last_next;
            evid_reg    <= evid_next;
            src_reg     <= src_next;
            autoRet_reg <= autoRet_next;
            type_reg    <= type_next;
        end
    end

    // Outputs straight from registers
    assign reqReady      = ready_reg;
    assign reqError      = err_reg;
    assign outValid      = valid_reg;
    assign outData       = data_reg;
    assign outFirst      = first_reg;
    assign outLast       = last_reg;
    assign eventId       = evid_reg;
    assign eventSource   = src_reg;
    assign autoReturnBit = autoRet_reg;

    // Checks on the composed stream
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    logic accepted;  // Request taken this cycle
    assign accepted = reqValid && ready_reg && srcOk && typeOk;

    AST_SRC_REFUSED: // [RULE1]
    assert property (reqValid && ready_reg && !srcOk |=> reqError && !outValid)
        else $error("illegal cue source not refused");

    AST_FIRST_BYTE_TYPE: // [RULE12]
    assert property (accepted |=> outValid && outFirst && outData == $past(insertType))
        else $error("first byte is not the insert type");

    AST_EVID_LAYOUT: // [RULE13]
    assert property (accepted |=> eventId == {$past(cueSource), $past(evIf.number)})
        else $error("event id not source over number");

    AST_EVNUM_STEPS: // [RULE3]
    assert property (accepted |=> evIf.number == $past(evIf.number) + 28'h0000001)
        else $error("event number did not advance");

    AST_PREROLL_ZERO: // [RULE6]
    assert property (outValid && idx_reg == IDX_PREROLL && type_reg != TYPE_START_NORMAL
                     && type_reg != TYPE_END_NORMAL |-> outData == 8'h00)
        else $error("pre-roll sent for a type that ignores it");

    AST_BREAK_ZERO: // [RULE7]
    assert property (outValid && idx_reg == IDX_BREAK && type_reg != TYPE_START_NORMAL
                     && type_reg != TYPE_START_IMMED |-> outData == 8'h00)
        else $error("break sent for a type that ignores it");

    AST_FLAG_LAST: // [RULE11]
    assert property (outValid && idx_reg == IDX_AUTORET |-> outLast && outData == AUTO_RETURN_FLAG)
        else $error("closing flag byte wrong");

    AST_AUTORET_LOW: // [RULE10]
    assert property (accepted |=> !autoReturnBit)
        else $error("auto-return set with flag fixed at zero");

    AST_STALL_HOLDS:
    assert property (outValid && !outReady |=> outValid && $stable(outData) && $stable(idx_reg))
        else $error("byte changed while stalled");

    COV_START_NORMAL:
    cover property (accepted && insertType == TYPE_START_NORMAL ##[1:60] outValid && outLast && outReady);

    COV_CANCEL:
    cover property (accepted && insertType == TYPE_CANCEL);

    COV_REFUSED:
    cover property (reqError);

    COV_STALL:
    cover property (outValid && !outReady ##1 outValid && outReady);

endmodule

/* design/splice_pkg.sv */
// Constants and types shared by the splice-request field composer
package splice_pkg;

    // Field widths
    localparam int unsigned SRC_W     = 4;   // Cue-source code width, top of event id
    localparam int unsigned EVNUM_W   = 28;  // Generated event number width
    localparam int unsigned EVID_W    = 32;  // Full splice event identifier
    localparam int unsigned BYTE_W    = 8;   // Stream byte width
    localparam int unsigned MSG_BYTES = 14;  // Bytes in one splice-request field block
    localparam int unsigned MSG_W     = MSG_BYTES * BYTE_W;
    localparam int unsigned IDX_W     = 4;   // Byte index counter width

    // Byte positions within the field block
    localparam logic [IDX_W-1:0] IDX_TYPE     = 4'h0;
    localparam logic [IDX_W-1:0] IDX_PREROLL  = 4'h7;
    localparam logic [IDX_W-1:0] IDX_BREAK    = 4'h9;
    localparam logic [IDX_W-1:0] IDX_AUTORET  = 4'hD;
    localparam logic [IDX_W-1:0] IDX_LAST     = 4'hD;

    // Insert type codes
    localparam logic [7:0] TYPE_START_NORMAL = 8'h01;
    localparam logic [7:0] TYPE_START_IMMED  = 8'h02;
    localparam logic [7:0] TYPE_END_NORMAL   = 8'h03;
    localparam logic [7:0] TYPE_END_IMMED    = 8'h04;
    localparam logic [7:0] TYPE_CANCEL       = 8'h05;

    // Cue-source codes and their meanings
    typedef enum logic [SRC_W-1:0] {
        SRC_EMBEDDED   = 4'h0,  // Cue embedded in the source material
        SRC_AUTOMATION = 4'h4,  // Automation switching
        SRC_LIVE_EVENT = 4'h8,  // Live event trigger system
        SRC_LOCAL_REPL = 4'hC   // Local content replacement
    } cue_src_t;

    // Fixed auto-return flag and reset values
    localparam logic [7:0]         AUTO_RETURN_FLAG = 8'h00;
    localparam logic [EVNUM_W-1:0] EVNUM_RESET      = 28'h0000000;
    localparam logic [EVID_W-1:0]  EVID_RESET       = 32'h00000000;

endpackage

/* design/event_num_if.sv */
// Carrier between the composer and its event number generator
interface event_num_if;
    logic                            advance;  // One-cycle pulse: number consumed
    logic [splice_pkg::EVNUM_W-1:0]  number;   // Current event number

    modport gen  (input advance, output number);
    modport user (output advance, input number);
endinterface

/* design/event_counter.sv */
// Splice event number generator, stepped only when a number is consumed
module event_counter
    import splice_pkg::*;
(
    input  wire logic  mclk,   // System clock
    input  wire logic  rst_n,  // Synchronous reset, active low
    event_num_if.gen   evIf    // Advance request and current number
);

    logic [EVNUM_W-1:0] number_reg;   // Number handed to the next message
    logic [EVNUM_W-1:0] number_next;

    // Step once per consumed number; wraps inside 28 bits
    always_comb
    begin
        number_next = number_reg;
        if (evIf.advance)
        begin
            number_next = number_reg + 28'h0000001;  // [RULE3]
        end
    end

    // Register the number
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            number_reg <= EVNUM_RESET;
        end
        else
        begin
            number_reg <= number_next;
        end
    end

    assign evIf.number = number_reg;

endmodule

/* test/cue_sink.sv */
// Downstream inserter model that takes the composed field bytes
module cue_sink
(
    input  wire logic mclk,     // System clock
    input  wire logic rst_n,    // Reset, active low
    input  wire logic outValid, // Byte offered by the composer
    input  wire logic slowMode, // High: stall at random
    output logic      outReady  // Byte taken at the next edge when high
);
    timeunit 1ns;
    timeprecision 100ps;

    initial outReady = 1'b0;

    // Ready moves just after each edge; kept low in reset so nothing is taken early
    always @(posedge mclk)
    begin
        outReady <= #1 rst_n && (!slowMode || ($urandom_range(3) != 0));
    end
endmodule

/* test/tb_top.sv */
// Self-checking bench for the splice-request field composer
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import splice_pkg::*;

    logic               mclk;           // System clock
    logic               rst_n;          // Reset, active low
    logic               reqValid;       // Request offered
    logic               reqReady;       // Composer idle
    logic [7:0]         insertType;     // Insert type
    logic [SRC_W-1:0]   cueSource;      // Cue source
    logic [15:0]        programId;      // Program id
    logic [15:0]        preRollMs;      // Pre-roll
    logic [15:0]        breakTenths;    // Break duration
    logic [7:0]         availNum;       // Avail number
    logic [7:0]         availsExpected; // Avail count
    logic               reqError;       // Refusal pulse
    logic               outValid;       // Byte valid
    logic               outReady;       // Byte taken
    logic [BYTE_W-1:0]  outData;        // Field byte
    logic               outFirst;       // First byte
    logic               outLast;        // Last byte
    logic [EVID_W-1:0]  eventId;        // Event id
    cue_src_t           eventSource;    // Decoded source
    logic               autoReturnBit;  // Auto-return bit
    logic               slowMode;       // Sink stalls when high
    logic [EVNUM_W-1:0] evNum;          // Expected next event number
    logic [10:0]        byteQ[$];       // Notes: {refused, first, last, byte}
    logic [EVID_W-1:0]  idQ[$];         // Notes: event id per block
    logic [10:0]        note;           // Oldest note under comparison
    int                 error_cnt;      // Mismatches
    int                 num_checks;     // Comparisons made

    splice_fields dut (.mclk, .rst_n, .reqValid, .reqReady, .insertType, .cueSource, .programId,
        .preRollMs, .breakTenths, .availNum, .availsExpected, .reqError, .outValid, .outReady,
        .outData, .outFirst, .outLast, .eventId, .eventSource, .autoReturnBit);

    cue_sink sink (.mclk, .rst_n, .outValid, .slowMode, .outReady);

    initial mclk = 1'b0;
    always #5 mclk = ~mclk;

    // One comparison, reported at once on a mismatch
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Offer one request, hold it until taken, then note what must come out
    task automatic send(input logic [7:0] ty, input logic [3:0] src, input logic [15:0] pid,
                        input logic [15:0] pre, input logic [15:0] brk, input logic [7:0] an, input logic [7:0] ae);
        logic [MSG_W-1:0] blk;
        logic             r;
        r = 1'b0;
        blk = {ty, src, evNum, pid, (ty == 8'h01 || ty == 8'h03) ? pre : 16'h0000,
               (ty == 8'h01 || ty == 8'h02) ? brk : 16'h0000, an, ae, 8'h00};
        @(posedge mclk);
        #1;
        reqValid = 1'b1;
        insertType = ty;
        cueSource = src;
        programId = pid;
        preRollMs = pre;
        breakTenths = brk;
        availNum = an;
        availsExpected = ae;
        while (!r)
        begin
            @(negedge mclk);
            r = reqReady;
            @(posedge mclk);
        end
        // Refused requests must not consume an event number
        if (src[1:0] == 2'h0 && ty >= 8'h01 && ty <= 8'h05)
        begin
            idQ.push_back({src, evNum});
            for (int i = 0; i < MSG_BYTES; i++)
                byteQ.push_back({1'b0, i == 0, i == MSG_BYTES - 1, blk[MSG_W-1-8*i -: 8]});
            evNum = evNum + 1'b1;
        end
        else
            byteQ.push_back(11'h400);
        #1;
        reqValid = 1'b0;
    endtask

    // Request with random field values
    task automatic rnd(input logic [7:0] ty, input logic [3:0] src);
        send(ty, src, 16'($urandom), 16'($urandom), 16'($urandom), 8'($urandom), 8'($urandom));
    endtask

    // Wait, bounded, until every note has been retired
    task automatic drain();
        int n;
        n = 0;
        while (byteQ.size() != 0 && n < 3000)
        begin
            @(posedge mclk);
            n++;
        end
        chk(32'(byteQ.size()), 32'h0);
        repeat (3) @(posedge mclk);
        #1;
    endtask

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Watcher on the falling edge, where the registered outputs are settled
    always @(negedge mclk)
    begin
        if (rst_n && outValid && outReady)
        begin
            note = (byteQ.size() != 0) ? byteQ.pop_front() : 11'h7FF;
            chk({22'h0, outFirst, outLast, outData}, {21'h0, note});
            if (outFirst && idQ.size() != 0)
            begin
                chk(eventId, idQ[0]);
                chk({28'h0, eventSource}, {28'h0, idQ[0][31:28]});
                idQ.delete(0);
            end
            chk({31'h0, autoReturnBit}, 32'h0);
        end
        if (rst_n && reqError)
        begin
            note = (byteQ.size() != 0) ? byteQ.pop_front() : 11'h7FF;
            chk({21'h0, note}, 32'h400);
        end
    end

    // Main sequence
    initial
    begin
        error_cnt = 0;
        num_checks = 0;
        evNum = '0;
        slowMode = 1'b0;
        rst_n = 1'b0;
        reqValid = 1'b0;
        insertType = 8'h00;
        cueSource = 4'h0;
        programId = 16'h0000;
        preRollMs = 16'h0000;
        breakTenths = 16'h0000;
        availNum = 8'h00;
        availsExpected = 8'h00;
        void'($urandom(32'h25759EF2));
        repeat (12) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        @(negedge mclk);
        chk({30'h0, reqReady, outValid}, 32'h2);
        // Every insert type once, each legal source in turn
        for (int t = 1; t <= 5; t++)
            rnd(8'(t), 4'(4 * (t % 4)));
        drain();
        $display("Test 1 done");
        // Field extremes and random traffic with a stalling sink
        slowMode = 1'b1;
        send(8'h01, 4'hC, 16'hFFFF, 16'hFFFF, 16'hFFFF, 8'hFF, 8'hFF);
        send(8'h02, 4'h8, 16'h0000, 16'hFFFF, 16'h0000, 8'h00, 8'h00);
        send(8'h03, 4'h4, 16'h8001, 16'h0001, 16'hFFFF, 8'h01, 8'h00);
        for (int k = 0; k < 20; k++)
            rnd(8'($urandom_range(5, 1)), 4'($urandom_range(3) * 4));
        drain();
        $display("Test 2 done");
        // Refused sources and types leave the event number alone
        for (int s = 0; s < 16; s++)
            if (s % 4 != 0)
                rnd(8'h01, 4'(s));
        rnd(8'h00, 4'h0);
        rnd(8'h06, 4'h4);
        rnd(8'hFF, 4'h8);
        rnd(8'h04, 4'h0);
        drain();
        $display("Test 3 done");
        // A second reset restarts the event number from zero
        rst_n = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        evNum = '0;
        rnd(8'h05, 4'hC);
        rnd(8'h01, 4'h0);
        drain();
        $display("Test 4 done");
        print_verdict();
    end

    // Watchdog, far beyond the several hundred cycles the tests need
    initial
    begin
        #500000;
        error_cnt++;
        print_verdict();
    end
endmodule
